// file: rtl/itfd_pkg.sv
// Constants for the input terminal function decoder.
// Assumes one 250 MHz clock and a synchronous active-low reset.
// How it works
// - Each terminal obeys its programmed function code
// - Per-terminal polarity applied before function decoding
// - Code 00 runs forward while active
// - Code 01 runs reverse while active
// - Codes 02..05 form speed index, bits 0..3
// - Code 06 runs at jog frequency
// - External braking request enables braking in deceleration
// - Code 08 selects second motor parameter set
// - Code 09 selects second-stage ramp values
// - Code 11 switches output off, motor coasts
// - Code 12 rising edge latches trip until reset
// - Guard active at power-up blocks run resume
// - Code 14 hands motor to commercial mains
// - Code 15 locks parameter editing
// - Code 18 clears trips, output off, power-up reset
// - Code 19 only on terminal 5: thermistor trip
// - Polarity 00 active high, 01 active low
// - Reset function never uses active-low polarity
// - Response time 0..200 steps of 2 ms, skipped at reset
// - Same function on several terminals is ORed

package itfd_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_TERM  = 7;
  localparam int FUNC_W    = 5;
  localparam int RESP_W    = 8;
  localparam int NUM_CODES = 20;

  // ----------------------------------------------------------------
  // Response time
  // ----------------------------------------------------------------
  localparam int            CLK_MHZ      = 250;
  localparam int            STEP_TIME_MS = 2;
  localparam int            STEP_CYCLES  = STEP_TIME_MS * 1000 * CLK_MHZ;
  localparam logic [RESP_W-1:0] RESP_MAX = 8'hc8;
  localparam logic [RESP_W-1:0] RESP_RESET = 8'h01;

  // ----------------------------------------------------------------
  // Function codes
  // ----------------------------------------------------------------
  localparam logic [FUNC_W-1:0] FC_FORWARD   = 5'h00;
  localparam logic [FUNC_W-1:0] FC_REVERSE   = 5'h01;
  localparam logic [FUNC_W-1:0] FC_SPEED_B0  = 5'h02;
  localparam logic [FUNC_W-1:0] FC_SPEED_B1  = 5'h03;
  localparam logic [FUNC_W-1:0] FC_SPEED_B2  = 5'h04;
  localparam logic [FUNC_W-1:0] FC_SPEED_B3  = 5'h05;
  localparam logic [FUNC_W-1:0] FC_JOG       = 5'h06;
  localparam logic [FUNC_W-1:0] FC_DC_BRAKE  = 5'h07;
  localparam logic [FUNC_W-1:0] FC_MOTOR2    = 5'h08;
  localparam logic [FUNC_W-1:0] FC_RAMP2     = 5'h09;
  localparam logic [FUNC_W-1:0] FC_COAST     = 5'h0b;
  localparam logic [FUNC_W-1:0] FC_OUT_TRIP  = 5'h0c;
  localparam logic [FUNC_W-1:0] FC_GUARD     = 5'h0d;
  localparam logic [FUNC_W-1:0] FC_MAINS     = 5'h0e;
  localparam logic [FUNC_W-1:0] FC_LOCK      = 5'h0f;
  localparam logic [FUNC_W-1:0] FC_RESET     = 5'h12;
  localparam logic [FUNC_W-1:0] FC_THERM     = 5'h13;

  // Terminal 5 is the only one wired to the thermistor comparator
  localparam int THERM_TERM = 4;

  // ----------------------------------------------------------------
  // Polarity codes and reset values
  // ----------------------------------------------------------------
  localparam logic POL_NO = 1'b0;
  localparam logic POL_NC = 1'b1;
  localparam logic PREV_TRIP_RESET = 1'b1;

endpackage : itfd_pkg

// file: rtl/itfd_resp_filter.sv
// Response time filter for one input terminal.
// Assumes the raw level is already synchronous to clock_i.
`timescale 1ns/100ps

module itfd_resp_filter #(
  parameter int STEP_CYCLES = itfd_pkg::STEP_CYCLES
) (
  // Clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        rst_n_i,
  // Terminal
  input  wire logic                        raw_i,
  input  wire logic [itfd_pkg::RESP_W-1:0] resp_time_i,
  // Filtered level
  output logic                             level_o,
  output logic                             ready_o
);
  import itfd_pkg::*;

  localparam int PRE_W = $clog2(STEP_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYCLES - 1);

  logic              level_reg;
  logic              ready_reg;
  logic [PRE_W-1:0]  pre_reg;
  logic [RESP_W-1:0] step_reg;
  logic [RESP_W-1:0] limit;
  logic              differ;
  logic              step_tick;
  logic              accept;

  // Out-of-range settings are clamped to the longest delay
  assign limit     = (resp_time_i > RESP_MAX) ? RESP_MAX : resp_time_i;
  assign differ    = (raw_i != level_reg);
  assign step_tick = (pre_reg == PRE_LAST);
  assign accept    = differ && (step_reg >= limit);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      level_reg <= 1'b0;
      ready_reg <= 1'b0;
      pre_reg   <= '0;
      step_reg  <= '0;
    end else if (!ready_reg) begin
      // First level after reset skips the delay
      level_reg <= raw_i;
      ready_reg <= 1'b1;
    end else if (!differ || accept) begin
      level_reg <= raw_i;
      pre_reg   <= '0;
      step_reg  <= '0;
    end else begin
      pre_reg <= step_tick ? '0 : pre_reg + PRE_W'(1);
      if (step_tick) begin
        step_reg <= step_reg + RESP_W'(1);
      end
    end
  end

  assign level_o = level_reg;
  assign ready_o = ready_reg;

endmodule : itfd_resp_filter

// file: rtl/itfd_top.sv
// Decoder for seven programmable logic input terminals of a drive.
// Assumes terminal levels and settings are synchronous to clock_i;
// the thermistor comparator sits outside and gives two flags.
`timescale 1ns/100ps

module itfd_top #(
  parameter int STEP_CYCLES = itfd_pkg::STEP_CYCLES
) (
  // Clock and reset
  input  wire logic                          clock_i,
  input  wire logic                          rst_n_i,
  // Terminals and their settings
  input  wire logic [itfd_pkg::NUM_TERM-1:0] term_i,
  input  wire logic [itfd_pkg::FUNC_W-1:0]
                    terminal_function_select_i [itfd_pkg::NUM_TERM],
  input  wire logic [itfd_pkg::NUM_TERM-1:0] terminal_polarity_select_i,
  input  wire logic [itfd_pkg::RESP_W-1:0]
                    terminal_response_time_i [itfd_pkg::NUM_TERM],
  // Thermistor comparator
  input  wire logic                          therm_over_temp_i,
  input  wire logic                          therm_open_i,
  // Run commands
  output logic                               run_o,
  output logic                               reverse_o,
  output logic                               jog_run_o,
  output logic [3:0]                         speed_index_o,
  // Drive modes
  output logic                               dc_brake_request_o,
  output logic                               second_motor_o,
  output logic                               second_ramp_select_o,
  output logic                               coast_stop_o,
  output logic                               commercial_power_o,
  output logic                               parameter_lock_o,
  output logic                               motor_output_off_o,
  // Reset and trips
  output logic                               drive_reset_o,
  output logic                               outside_trip_o,
  output logic                               thermistor_trip_o,
  output logic                               power_up_restart_guard_o
);
  import itfd_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Thermistor code is only meaningful on its dedicated terminal
  function automatic logic itfd_code_ok(input logic [FUNC_W-1:0] code,
                                        input int               term);
    itfd_code_ok = (code < FUNC_W'(NUM_CODES)) &&
                   ((code != FC_THERM) || (term == THERM_TERM));
  endfunction : itfd_code_ok

  // ----------------------------------------------------------------
  // Per-terminal filtering and polarity
  // ----------------------------------------------------------------
  logic [NUM_TERM-1:0]  filt_level;
  logic [NUM_TERM-1:0]  filt_ready;
  logic [NUM_TERM-1:0]  term_active;
  logic [NUM_TERM-1:0]  code_terms [NUM_CODES];
  logic [NUM_CODES-1:0] func_on;

  genvar t;
  genvar c;
  generate
    for (t = 0; t < NUM_TERM; t++) begin : g_term
      logic eff_pol;

      itfd_resp_filter #(
        .STEP_CYCLES (STEP_CYCLES)
      ) u_filter (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .raw_i       (term_i[t]),
        .resp_time_i (terminal_response_time_i[t]),
        .level_o     (filt_level[t]),
        .ready_o     (filt_ready[t])
      );

      // Reset function is forced to normally open
      assign eff_pol = (terminal_function_select_i[t] == FC_RESET) ?
                       POL_NO : terminal_polarity_select_i[t];
      // NC inverts the contact sense
      assign term_active[t] = filt_level[t] ^ (eff_pol == POL_NC);
    end

    for (c = 0; c < NUM_CODES; c++) begin : g_code
      for (t = 0; t < NUM_TERM; t++) begin : g_hit
        // Terminal takes the role of its programmed code
        assign code_terms[c][t] = term_active[t] &&
          (terminal_function_select_i[t] == FUNC_W'(c)) &&
          itfd_code_ok(terminal_function_select_i[t], t);
      end
      // Duplicated assignments behave as a logical OR
      assign func_on[c] = |code_terms[c];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Start-up sequencing
  // ----------------------------------------------------------------
  // The filters load their first level one cycle after reset, so the
  // power-up guard is sampled the cycle after that.
  logic all_ready;
  logic armed_reg;

  assign all_ready = &filt_ready;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      armed_reg <= 1'b0;
    end else if (all_ready) begin
      armed_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Run command decode
  // ----------------------------------------------------------------
  logic fwd_on;
  logic rev_on;
  logic jog_on;
  logic dir_run;
  logic run_req;
  logic reset_on;
  logic guard_on;

  assign fwd_on   = func_on[FC_FORWARD];
  assign rev_on   = func_on[FC_REVERSE];
  assign jog_on   = func_on[FC_JOG];
  assign reset_on = func_on[FC_RESET];
  assign guard_on = func_on[FC_GUARD];
  // Both directions at once is a stop
  assign dir_run  = fwd_on ^ rev_on;
  // Jog runs only when dir_run is low: no direction command, or both at once
  assign run_req  = dir_run | jog_on;

  // ----------------------------------------------------------------
  // Unattended start guard
  // ----------------------------------------------------------------
  // A run command standing at power-up with the guard active is held
  // off until the command is dropped; without the guard it resumes.
  logic block_reg;
  logic block_next;

  assign block_next = (!armed_reg) ? (guard_on & run_req)
                                   : (block_reg & run_req);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      block_reg <= 1'b0;
    end else if (all_ready) begin
      block_reg <= block_next;
    end
  end

  // ----------------------------------------------------------------
  // Trips
  // ----------------------------------------------------------------
  logic out_trip_prev_reg;
  logic out_trip_edge;
  logic therm_armed;
  logic therm_fault;
  logic out_trip_state;
  logic therm_trip_state;

  // A level already present at power-up is not taken as an edge
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      out_trip_prev_reg <= PREV_TRIP_RESET;
    end else if (all_ready) begin
      out_trip_prev_reg <= func_on[FC_OUT_TRIP];
    end
  end

  // Only the inactive-to-active change trips
  assign out_trip_edge = armed_reg & func_on[FC_OUT_TRIP] &
                         ~out_trip_prev_reg;

  // Analog use of terminal 5: the contact level does not matter
  assign therm_armed = (terminal_function_select_i[THERM_TERM] == FC_THERM);
  assign therm_fault = therm_armed &
                       (therm_over_temp_i | therm_open_i);

  itfd_trip_latch u_out_trip (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .set_i   (out_trip_edge),
    .clear_i (reset_on),
    .trip_o  (out_trip_state)
  );

  // The fault sets the latch on every cycle it stands, so a reset
  // terminal cannot clear a trip whose cause is still present
  itfd_trip_latch u_therm_trip (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .set_i   (therm_fault),
    .clear_i (reset_on),
    .trip_o  (therm_trip_state)
  );

  // ----------------------------------------------------------------
  // Output decode
  // ----------------------------------------------------------------
  logic       any_trip;
  logic       out_off;
  logic       run_ok;
  logic [3:0] speed_idx;

  assign any_trip = out_trip_state | therm_trip_state;
  // Coast, reset and any trip all cut the motor output
  assign out_off  = func_on[FC_COAST] | reset_on | any_trip;
  assign run_ok   = armed_reg & run_req & ~block_reg & ~out_off;
  assign speed_idx = {func_on[FC_SPEED_B3], func_on[FC_SPEED_B2],
                      func_on[FC_SPEED_B1], func_on[FC_SPEED_B0]};

  // ----------------------------------------------------------------
  // Run command registers
  // ----------------------------------------------------------------
  logic       run_reg;
  logic       reverse_reg;
  logic       jog_reg;
  logic [3:0] speed_reg;

  // Direction, jog and speed are taken on the same edge so that the
  // speed stage never sees a half-updated command
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      run_reg     <= 1'b0;
      reverse_reg <= 1'b0;
      jog_reg     <= 1'b0;
      speed_reg   <= 4'h0;
    end else begin
      run_reg     <= run_ok;
      reverse_reg <= run_ok & rev_on & ~fwd_on;
      jog_reg     <= run_ok & ~dir_run & jog_on;
      speed_reg   <= speed_idx;
    end
  end

  // ----------------------------------------------------------------
  // Mode level registers
  // ----------------------------------------------------------------
  // Plain levels: they follow their terminals and hold no history
  logic       brake_reg;
  logic       motor2_reg;
  logic       ramp2_reg;
  logic       coast_reg;
  logic       mains_reg;
  logic       lock_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      brake_reg   <= 1'b0;
      motor2_reg  <= 1'b0;
      ramp2_reg   <= 1'b0;
      coast_reg   <= 1'b0;
      mains_reg   <= 1'b0;
      lock_reg    <= 1'b0;
    end else begin
      brake_reg   <= func_on[FC_DC_BRAKE];
      motor2_reg  <= func_on[FC_MOTOR2];
      ramp2_reg   <= func_on[FC_RAMP2];
      coast_reg   <= func_on[FC_COAST];
      mains_reg   <= func_on[FC_MAINS];
      lock_reg    <= func_on[FC_LOCK];
    end
  end

  // ----------------------------------------------------------------
  // Protection status registers
  // ----------------------------------------------------------------
  logic       off_reg;
  logic       reset_reg;

  // Same latency as the run flop, so run_o is never seen high beside
  // a stop request in the same cycle
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      off_reg     <= 1'b0;
      reset_reg   <= 1'b0;
    end else begin
      off_reg     <= out_off;
      reset_reg   <= reset_on;
    end
  end

  assign run_o                    = run_reg;
  assign reverse_o                = reverse_reg;
  assign jog_run_o                = jog_reg;
  assign speed_index_o            = speed_reg;
  assign dc_brake_request_o       = brake_reg;
  assign second_motor_o           = motor2_reg;
  assign second_ramp_select_o     = ramp2_reg;
  assign coast_stop_o             = coast_reg;
  assign commercial_power_o       = mains_reg;
  assign parameter_lock_o         = lock_reg;
  assign motor_output_off_o       = off_reg;
  assign drive_reset_o            = reset_reg;
  assign outside_trip_o           = out_trip_state;
  assign thermistor_trip_o        = therm_trip_state;
  assign power_up_restart_guard_o = block_reg;

endmodule : itfd_top

// file: rtl/itfd_trip_latch.sv
// Sticky trip flag, set by an event and cleared by drive reset.
// Assumes set and clear are synchronous one-cycle or level terms.
`timescale 1ns/100ps

module itfd_trip_latch (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Control
  input  wire logic set_i,
  input  wire logic clear_i,
  // State
  output logic      trip_o
);
  import itfd_pkg::*;

  logic trip_reg;
  logic trip_next;

  // A trip arriving while reset is held is not lost
  assign trip_next = set_i | (trip_reg & ~clear_i);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      trip_reg <= 1'b0;
    end else begin
      trip_reg <= trip_next;
    end
  end

  assign trip_o = trip_reg;

endmodule : itfd_trip_latch

// file: sim/itfd_props.sv
// Concurrent checks on the ports of the terminal decoder top.
// Assumes the bind below and the registered timing of the decoder.
`timescale 1ns/100ps

module itfd_props (
  // Clock and reset
  input wire logic                          clock_i,
  input wire logic                          rst_n_i,
  // Settings
  input wire logic [itfd_pkg::FUNC_W-1:0]
                   terminal_function_select_i [itfd_pkg::NUM_TERM],
  // Watched outputs
  input wire logic                          run_o,
  input wire logic                          reverse_o,
  input wire logic                          jog_run_o,
  input wire logic                          coast_stop_o,
  input wire logic                          motor_output_off_o,
  input wire logic                          drive_reset_o,
  input wire logic                          outside_trip_o,
  input wire logic                          thermistor_trip_o,
  input wire logic                          power_up_restart_guard_o
);
  import itfd_pkg::*;

  logic ext_coded;

  always_comb begin
    ext_coded = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      ext_coded |= (terminal_function_select_i[i] == FC_OUT_TRIP);
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_trip_rise;
    $rose(outside_trip_o);
  endsequence
  sequence s_trip_fall;
    $fell(outside_trip_o);
  endsequence

  property p_ext_cause;
    s_trip_rise |-> $past(ext_coded);
  endproperty
  property p_trip_hold;
    s_trip_fall |-> (drive_reset_o || $past(drive_reset_o));
  endproperty
  property p_trip_stop;
    outside_trip_o |=> (!run_o && motor_output_off_o);
  endproperty
  property p_coast_off;
    coast_stop_o |-> motor_output_off_o;
  endproperty
  property p_stop_cmd;
    (coast_stop_o || drive_reset_o) |-> !run_o;
  endproperty
  property p_rev_run;
    reverse_o |-> run_o;
  endproperty
  property p_jog_dir;
    jog_run_o |-> !reverse_o;
  endproperty
  property p_therm_code;
    $rose(thermistor_trip_o) |->
      ($past(terminal_function_select_i[THERM_TERM]) == FC_THERM);
  endproperty
  property p_therm_off;
    thermistor_trip_o |=> motor_output_off_o;
  endproperty
  property p_guard;
    power_up_restart_guard_o |-> !run_o;
  endproperty

  a_ext_cause: assert property (p_ext_cause)
    else $error("trip rose with no edge terminal coded");
  a_trip_hold: assert property (p_trip_hold)
    else $error("trip cleared without drive reset");
  a_trip_stop: assert property (p_trip_stop)
    else $error("trip did not stop the output");
  a_coast_off: assert property (p_coast_off)
    else $error("coast without output off");
  a_stop_cmd: assert property (p_stop_cmd)
    else $error("run while coasting or in reset");
  a_rev_run: assert property (p_rev_run)
    else $error("reverse without run");
  a_jog_dir: assert property (p_jog_dir)
    else $error("jog together with reverse");
  a_therm_code: assert property (p_therm_code)
    else $error("thermistor trip on a wrong terminal");
  a_therm_off: assert property (p_therm_off)
    else $error("thermistor trip left output on");
  a_guard: assert property (p_guard)
    else $error("run while restart guard holds");

endmodule : itfd_props

bind itfd_top itfd_props u_itfd_props (
  .clock_i(clock_i), .rst_n_i(rst_n_i),
  .terminal_function_select_i(terminal_function_select_i),
  .run_o(run_o), .reverse_o(reverse_o), .jog_run_o(jog_run_o),
  .coast_stop_o(coast_stop_o), .motor_output_off_o(motor_output_off_o),
  .drive_reset_o(drive_reset_o), .outside_trip_o(outside_trip_o),
  .thermistor_trip_o(thermistor_trip_o),
  .power_up_restart_guard_o(power_up_restart_guard_o)
);

// file: sim/itfd_switch_model.sv
// Model of the contacts and relays wired to the seven terminals.
// Assumes the bench commands contact states on the rising edge.
`timescale 1ns/100ps

module itfd_switch_model (
  // Clock
  input  wire logic       clock_i,
  // Commanded contacts
  input  wire logic [6:0] contact_i,
  input  wire logic [6:0] bounce_i,
  // Terminal levels
  output logic      [6:0] term_o
);
  // A bounce flips a contact for one cycle, like a chattering relay
  always_ff @(posedge clock_i) begin
    term_o <= contact_i ^ bounce_i;
  end
endmodule : itfd_switch_model

// file: sim/tb.sv
// Self-checking bench for the terminal decoder.
// Assumes a short response step so that filter delays stay small.
`timescale 1ns/100ps

module tb;
  import itfd_pkg::*;

  logic clock_i, rst_n_i, t_over, t_open;
  logic [6:0] contact, bounce, term, pol;
  logic [FUNC_W-1:0] fsel [NUM_TERM];
  logic [RESP_W-1:0] resp [NUM_TERM];
  logic run_o, reverse_o, jog_run_o, dc_o, m2_o, ramp_o, coast_o;
  logic mains_o, lock_o, off_o, rst_o, trip_o, therm_o, guard_o;
  logic [3:0] speed_index_o;
  int err_count, compares;

  itfd_switch_model u_itfd_switch_model (.clock_i(clock_i),
    .contact_i(contact), .bounce_i(bounce), .term_o(term));

  itfd_top #(.STEP_CYCLES(4)) u_itfd_top (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .term_i(term), .terminal_function_select_i(fsel),
    .terminal_polarity_select_i(pol), .terminal_response_time_i(resp),
    .therm_over_temp_i(t_over), .therm_open_i(t_open), .run_o(run_o),
    .reverse_o(reverse_o), .jog_run_o(jog_run_o),
    .speed_index_o(speed_index_o), .dc_brake_request_o(dc_o),
    .second_motor_o(m2_o), .second_ramp_select_o(ramp_o),
    .coast_stop_o(coast_o), .commercial_power_o(mains_o),
    .parameter_lock_o(lock_o), .motor_output_off_o(off_o),
    .drive_reset_o(rst_o), .outside_trip_o(trip_o),
    .thermistor_trip_o(therm_o), .power_up_restart_guard_o(guard_o));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_c(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : wait_c

  // Model, filter and output stage add three edges of latency
  task automatic drive(input logic [6:0] c);
    @(posedge clock_i);
    contact <= c;
    wait_c(5);
  endtask : drive

  task automatic clr_cfg;
    @(posedge clock_i);
    for (int i = 0; i < NUM_TERM; i++) fsel[i] <= 5'h14;
    pol <= 7'h00;
    drive(7'h00);
  endtask : clr_cfg

  task automatic t_run_dir;
    logic [1:0] exp [4];
    logic [6:0] cin [4];
    exp = '{2'b10, 2'b11, 2'b00, 2'b00};
    cin = '{7'h01, 7'h02, 7'h03, 7'h00};
    @(posedge clock_i);
    fsel[0] <= FC_FORWARD;
    fsel[1] <= FC_REVERSE;
    for (int i = 0; i < 4; i++) begin
      drive(cin[i]);
      chk({run_o, reverse_o}, exp[i]);
    end
    clr_cfg;
  endtask : t_run_dir

  task automatic t_speed;
    @(posedge clock_i);
    for (int i = 0; i < 4; i++) fsel[i] <= FC_SPEED_B0 + 5'(i);
    fsel[4] <= FC_SPEED_B0;
    for (int v = 0; v < 16; v++) begin
      drive(7'(v));
      chk(speed_index_o, 8'(v));
    end
    drive(7'h10);
    chk(speed_index_o, 8'h01);
    clr_cfg;
  endtask : t_speed

  task automatic t_modes;
    logic [FUNC_W-1:0] code [7];
    code = '{FC_DC_BRAKE, FC_MOTOR2, FC_RAMP2, FC_COAST, FC_MAINS,
             FC_LOCK, FC_JOG};
    for (int i = 0; i < 7; i++) begin
      for (int p = 0; p < 2; p++) begin
        @(posedge clock_i);
        fsel[2] <= code[i];
        pol[2] <= 1'(p);
        drive(p ? 7'h00 : 7'h04);
        chk({dc_o, m2_o, ramp_o, coast_o, mains_o, lock_o, jog_run_o},
            8'h40 >> i);
        drive(p ? 7'h04 : 7'h00);
        chk({dc_o, m2_o, ramp_o, coast_o, mains_o, lock_o, jog_run_o},
            8'h00);
      end
    end
    clr_cfg;
  endtask : t_modes

  task automatic t_trip;
    @(posedge clock_i);
    fsel[0] <= FC_FORWARD;
    fsel[3] <= FC_OUT_TRIP;
    fsel[5] <= FC_RESET;
    drive(7'h01);
    chk({trip_o, off_o, run_o}, 8'h01);
    drive(7'h09);
    chk({trip_o, off_o, run_o}, 8'h06);
    drive(7'h01);
    chk({trip_o, off_o, run_o}, 8'h06);
    drive(7'h21);
    chk({rst_o, trip_o, off_o}, 8'h05);
    drive(7'h01);
    chk({rst_o, trip_o, run_o}, 8'h01);
    @(posedge clock_i);
    pol[5] <= 1'b1;
    drive(7'h01);
    chk(rst_o, 8'h00);
    clr_cfg;
  endtask : t_trip

  task automatic t_therm;
    @(posedge clock_i);
    fsel[0] <= FC_THERM;
    fsel[5] <= FC_RESET;
    t_over <= 1'b1;
    wait_c(5);
    chk(therm_o, 8'h00);
    for (int f = 0; f < 2; f++) begin
      @(posedge clock_i);
      fsel[4] <= FC_THERM;
      {t_open, t_over} <= f ? 2'b10 : 2'b01;
      wait_c(5);
      chk({therm_o, off_o}, 8'h03);
      @(posedge clock_i);
      {t_open, t_over} <= 2'b00;
      drive(7'h20);
      drive(7'h00);
      chk(therm_o, 8'h00);
    end
    clr_cfg;
  endtask : t_therm

  task automatic t_resp;
    @(posedge clock_i);
    fsel[0] <= FC_FORWARD;
    resp[0] <= 8'h01;
    bounce <= 7'h01;
    @(posedge clock_i);
    bounce <= 7'h00;
    wait_c(10);
    chk(run_o, 8'h00);
    @(posedge clock_i);
    contact <= 7'h01;
    wait_c(3);
    chk(run_o, 8'h00);
    wait_c(8);
    chk(run_o, 8'h01);
    @(posedge clock_i);
    resp[0] <= 8'h00;
    clr_cfg;
  endtask : t_resp

  task automatic t_powerup;
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    fsel[0] <= FC_FORWARD;
    resp[0] <= RESP_MAX;
    contact <= 7'h01;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    wait_c(6);
    chk(run_o, 8'h01);
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    resp[0] <= 8'h00;
    fsel[6] <= FC_GUARD;
    contact <= 7'h41;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    wait_c(6);
    chk({guard_o, run_o}, 8'h02);
    drive(7'h40);
    drive(7'h41);
    chk(run_o, 8'h01);
  endtask : t_powerup

  task automatic complete_run;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // Whole run is about five hundred cycles; the limit leaves ample margin
  initial begin
    #60000;
    err_count++;
    complete_run;
  end

  initial begin
    rst_n_i = 1'b0;
    contact = 7'h00;
    bounce = 7'h00;
    pol = 7'h00;
    t_over = 1'b0;
    t_open = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      fsel[i] = 5'h14;
      resp[i] = 8'h00;
    end
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    wait_c(4);
    t_run_dir;
    t_speed;
    t_modes;
    t_trip;
    t_therm;
    t_resp;
    t_powerup;
    complete_run;
  end
endmodule : tb
